// ===== asc_defines.svh
// constants for the ascii framed query responder
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
`define ASC_CLK_HZ 200000000
`define ASC_BAUD_0 1200
`define ASC_BAUD_1 2400
`define ASC_BAUD_2 4800
`define ASC_BAUD_3 9600
`define ASC_BAUD_4 19200
`define ASC_BAUD_5 38400
`define ASC_BAUD_6 57600
`define ASC_BAUD_7 115200
`define ASC_DEF_BAUD 3'h3
`define ASC_DEF_ADDR 7'h0e
`define ASC_NB_BASE 4'h8
`define ASC_STX 8'h02
`define ASC_ETX 8'h03
`define ASC_CR 8'h0d
`define ASC_SP 8'h20
`define ASC_PLUS 8'h2b
`define ASC_MINUS 8'h2d
`define ASC_CH_0 8'h30
`define ASC_CH_9 8'h39
`define ASC_CH_UA 8'h41
`define ASC_CH_UF 8'h46
`define ASC_CH_LA 8'h61
`define ASC_CH_LF 8'h66
`define ASC_HEX_ADJ 4'h9
`define ASC_HEX_ALPHA 8'h37
`define ASC_KW_CTL0 8'h53
`define ASC_KW_CTL1 8'h54
`define ASC_KW_QRY0 8'h44
`define ASC_KW_QRY1 8'h41
`define ASC_KW_REP0 8'h4d
`define ASC_KW_REP1 8'h44
`define ASC_CMD_FILTER 8'h4e
`define ASC_MEAS_N 9
`define ASC_BODY_MAX 5
`define ASC_HDR_LAST 5'd4
`define ASC_REC_LAST 5'd29
`define ASC_TRL_LAST 5'd2
`define ASC_R_MDIG 5'd6
`define ASC_R_MEND 5'd9
`define ASC_R_SPECIAL_FUNCTION_FIELD 5'd20
`endif

// ===== asc_host.sv
// host side serial model: sends command frames, collects replies
`timescale 1ns/1ps
`default_nettype none
module asc_host
#(
  parameter int DIV = 5
)
(
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  byte rx_q[$];
  byte b;
  initial rxd = 1'b1;
  // ---
  // sender and receiver
  // ---
  // ten-bit frames at the reset rate
  task automatic send(input byte c);
    for (int i = 0; i < 10; i++)
    begin
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i-1];
      repeat (DIV) @(posedge clk);
    end
  endtask
  // mid-bit sampling; stop bit not checked, so a framing slip shows as a wrong char
  initial forever
  begin
    @(negedge txd);
    repeat (DIV / 2 + DIV) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = txd;
      repeat (DIV) @(posedge clk);
    end
    rx_q.push_back(b);
  end
endmodule // asc_host
`default_nettype wire

// ===== asc_pkg.sv
// types shared by the ascii framed query responder
package asc_pkg;
  typedef enum logic [1:0] {ASC_PAR_NONE = 2'h0, ASC_PAR_ODD = 2'h1, ASC_PAR_EVEN = 2'h2} asc_par_e;
  typedef enum logic [2:0] {
    ASC_P_IDLE = 3'h0, ASC_P_KW1 = 3'h1, ASC_P_KW2 = 3'h2, ASC_P_BODY = 3'h3, ASC_P_CK1 = 3'h4, ASC_P_CK2 = 3'h5
  } asc_pst_e;
  typedef enum logic [2:0] {
    ASC_R_OFF = 3'h0, ASC_R_HDR = 3'h1, ASC_R_MEAS = 3'h2, ASC_R_TRL = 3'h3, ASC_R_DONE = 3'h4
  } asc_rph_e;
endpackage

// ===== asc_responder.sv
// ascii framed query responder: frame parser, control command and data reply
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
// ----------------------------------------
// Functional notes
// - seven/eight data, one/two stop, parity selectable
// - rate 1200 to 115200, 9600 after reset
// - address 0-127, three digits, zero/space padded
// - address 14 after reset
// - frame starts STX, ends ETX or CR
// - ETX adds two checksum chars, CR none
// - checksum XORs all chars incl STX, ETX
// - checksum sent as two hex chars
// - control only outside service, with zero/span option
// - letter N starts filter change
// - control: keyword, address, space, letter; address matches
// - malformed or foreign control silently ignored
// - query without address allows no space
// - reply only to well-formed matching query
// - reply: STX, keyword, count, measurement records
// - reply terminator mirrors the query's
// - record address increments from instrument address
// - value: signed mantissa, signed exponent
// - status: operating and error bytes in hex
// - special-function field is ten zeros
// - invalid measurement reported as zero
// - nine measurements in fixed order
// - operating status bit layout
// - error status bit layout
// ----------------------------------------
module asc_responder
#(
  parameter int CLK_HZ = `ASC_CLK_HZ,
  parameter int MEAS_N = `ASC_MEAS_N
)
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic RXD,
  output logic TXD,
  input wire logic CFG_LOAD,
  input wire logic [6:0] CFG_ADDR,
  input wire logic [2:0] CFG_BAUD,
  input wire logic CFG_EIGHT_BITS,
  input wire logic CFG_TWO_STOP,
  input wire asc_pkg::asc_par_e CFG_PARITY,
  input wire logic SERVICE_MODE,
  input wire logic LOCAL_MAINT,
  input wire logic PUMP_OFF,
  input wire logic HEATER_OFF,
  input wire logic FILTER_CHANGING,
  input wire logic ZS_OPTION,
  input wire logic ERR_FILTER_COUNT,
  input wire logic ERR_FILTER_CHANGE,
  input wire logic ERR_BETA_DET,
  input wire logic ERR_DET_BOARD,
  input wire logic ERR_MAINBOARD,
  input wire logic ERR_FLOW,
  input wire logic [MEAS_N-1:0] MEAS_VALID,
  input wire logic [MEAS_N-1:0] MEAS_MANT_NEG,
  input wire logic [16*MEAS_N-1:0] MEAS_MANT,
  input wire logic [MEAS_N-1:0] MEAS_EXP_NEG,
  input wire logic [8*MEAS_N-1:0] MEAS_EXP,
  output logic FILTER_CHANGE_START,
  output logic REPLY_ACTIVE,
  output logic [6:0] INSTR_ADDR
);
  import asc_pkg::*;

  logic [2:0] baud_q;
  logic eight_q;
  logic two_q;
  asc_par_e par_q;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_ready;
  asc_pst_e pst_q;
  logic ctl_q;
  logic [7:0] body_q [`ASC_BODY_MAX];
  logic [2:0] len_q;
  logic ovf_q;
  logic [7:0] ck_q;
  logic [3:0] hi_q;
  logic [4:0] hx;
  logic fire_cr;
  logic fire;
  logic ck_bad;
  logic ctl_ok;
  logic qry_ok;
  asc_rph_e rph_q;
  logic [3:0] idx_q;
  logic [4:0] pos_q;
  logic [7:0] rck_q;
  logic rcr_q;
  logic [7:0] tx_data_q;
  logic tx_valid_q;
  logic [7:0] cur_ch;
  logic [7:0] ra;
  logic [15:0] mv;
  logic [7:0] ev;
  logic [7:0] op_st;
  logic [7:0] err_st;
  logic [39:0] hdr;
  logic [239:0] rec;
  logic [23:0] trl;
  logic [39:0] hdr_sh;
  logic [239:0] rec_sh;
  logic [23:0] trl_sh;

  // ----------------------------------------
  // character helpers
  // ----------------------------------------
  function automatic logic isdig(input logic [7:0] c);
    return (c >= `ASC_CH_0) && (c <= `ASC_CH_9);
  endfunction

  function automatic logic [9:0] dval(input logic [7:0] c);
    return isdig(c) ? {6'h0, c[3:0]} : 10'h0;
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? {4'h3, n} : (`ASC_HEX_ALPHA + {4'h0, n});
  endfunction

  function automatic logic [4:0] hexv(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h0;
    if (isdig(c))
      r = {1'b1, c[3:0]};
    else if ((c >= `ASC_CH_UA && c <= `ASC_CH_UF) || (c >= `ASC_CH_LA && c <= `ASC_CH_LF))
      r = {1'b1, c[3:0] + `ASC_HEX_ADJ};
    return r;
  endfunction

  // leading spaces only, at least one digit, value equal to own address
  function automatic logic addr_ok(input logic [7:0] c2, input logic [7:0] c1, input logic [7:0] c0,
                                   input logic [6:0] a);
    logic ok;
    logic [9:0] v;
    ok = isdig(c0) && (isdig(c1) || (c1 == `ASC_SP && c2 == `ASC_SP)) && (isdig(c2) || c2 == `ASC_SP);
    v = dval(c2) * 10'd100 + dval(c1) * 10'd10 + dval(c0);
    return ok && (v == {3'h0, a});
  endfunction

  // ----------------------------------------
  // configuration
  // ----------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      baud_q <= `ASC_DEF_BAUD;
      INSTR_ADDR <= `ASC_DEF_ADDR;
      eight_q <= 1'b1;
      two_q <= 1'b0;
      par_q <= ASC_PAR_NONE;
    end
    else if (CFG_LOAD)
    begin
      baud_q <= CFG_BAUD;
      INSTR_ADDR <= CFG_ADDR;
      eight_q <= CFG_EIGHT_BITS;
      two_q <= CFG_TWO_STOP;
      par_q <= CFG_PARITY;
    end
  end

  a_addr_reset: assert property (@(posedge CORE_CLK) !RESET_N |=> INSTR_ADDR == `ASC_DEF_ADDR)
    else $error("address not 14 after reset");

  asc_uart #(.CLK_HZ(CLK_HZ)) u_uart (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .rxd(RXD),
    .baud_sel(baud_q),
    .eight(eight_q),
    .two_stop(two_q),
    .parity(par_q),
    .tx_data(tx_data_q),
    .tx_valid(tx_valid_q),
    .tx_ready(tx_ready),
    .txd(TXD),
    .rx_valid(rx_valid),
    .rx_data(rx_data)
  );

  // ----------------------------------------
  // frame parser
  // ----------------------------------------
  assign hx = hexv(rx_data);
  assign fire_cr = rx_valid && (pst_q == ASC_P_BODY) && (rx_data == `ASC_CR);
  // second hex char closes an ETX frame
  assign ck_bad = rx_valid && (pst_q == ASC_P_CK2) && !(hx[4] && ({hi_q, hx[3:0]} == ck_q));
  assign fire = fire_cr || (rx_valid && (pst_q == ASC_P_CK2) && !ck_bad);

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      pst_q <= ASC_P_IDLE;
      ctl_q <= 1'b0;
      len_q <= '0;
      ovf_q <= 1'b0;
      ck_q <= '0;
      hi_q <= '0;
    end
    else if (rx_valid)
    begin
      // a start character restarts collection anywhere
      if (rx_data == `ASC_STX)
      begin
        pst_q <= ASC_P_KW1;
        ck_q <= `ASC_STX;
        len_q <= '0;
        ovf_q <= 1'b0;
      end
      else
      begin
        case (pst_q)
          ASC_P_KW1:
          begin
            ck_q <= ck_q ^ rx_data;
            ctl_q <= (rx_data == `ASC_KW_CTL0);
            pst_q <= (rx_data == `ASC_KW_CTL0 || rx_data == `ASC_KW_QRY0) ? ASC_P_KW2 : ASC_P_IDLE;
          end
          ASC_P_KW2:
          begin
            ck_q <= ck_q ^ rx_data;
            pst_q <= (rx_data == (ctl_q ? `ASC_KW_CTL1 : `ASC_KW_QRY1)) ? ASC_P_BODY : ASC_P_IDLE;
          end
          ASC_P_BODY:
          begin
            ck_q <= ck_q ^ rx_data;
            if (rx_data == `ASC_CR)
              pst_q <= ASC_P_IDLE;
            else if (rx_data == `ASC_ETX)
              pst_q <= ASC_P_CK1;
            else if (len_q == 3'(`ASC_BODY_MAX))
              ovf_q <= 1'b1;
            else
            begin
              body_q[len_q] <= rx_data;
              len_q <= len_q + 1'b1;
            end
          end
          ASC_P_CK1:
          begin
            hi_q <= hx[3:0];
            pst_q <= hx[4] ? ASC_P_CK2 : ASC_P_IDLE;
          end
          default:
            pst_q <= ASC_P_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // body decode
  // ----------------------------------------
  always_comb
  begin
    ctl_ok = 1'b0;
    qry_ok = 1'b0;
    // control forms with and without address and space
    case (len_q)
      3'h1: ctl_ok = (body_q[0] == `ASC_CMD_FILTER);
      3'h2: ctl_ok = (body_q[0] == `ASC_SP) && (body_q[1] == `ASC_CMD_FILTER);
      3'h4: ctl_ok = addr_ok(body_q[0], body_q[1], body_q[2], INSTR_ADDR) && (body_q[3] == `ASC_CMD_FILTER);
      3'h5: ctl_ok = addr_ok(body_q[0], body_q[1], body_q[2], INSTR_ADDR) && (body_q[3] == `ASC_SP)
                     && (body_q[4] == `ASC_CMD_FILTER);
      default: ctl_ok = 1'b0;
    endcase
    // a lone space without address is not a query form
    case (len_q)
      3'h0: qry_ok = 1'b1;
      3'h3: qry_ok = addr_ok(body_q[0], body_q[1], body_q[2], INSTR_ADDR);
      3'h4: qry_ok = ((body_q[0] == `ASC_SP) && addr_ok(body_q[1], body_q[2], body_q[3], INSTR_ADDR))
                     || (addr_ok(body_q[0], body_q[1], body_q[2], INSTR_ADDR) && (body_q[3] == `ASC_SP));
      default: qry_ok = 1'b0;
    endcase
    ctl_ok = ctl_ok && !ovf_q;
    qry_ok = qry_ok && !ovf_q;
  end

  // ----------------------------------------
  // control command
  // ----------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      FILTER_CHANGE_START <= 1'b0;
    else
      // gated filter change, everything else dropped
      FILTER_CHANGE_START <= fire && ctl_q && ctl_ok && !SERVICE_MODE && ZS_OPTION;
  end

  a_fc_gate: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    FILTER_CHANGE_START |-> $past(!SERVICE_MODE && ZS_OPTION && fire && ctl_q))
    else $error("filter change outside allowed mode");
  a_fc_cmd: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (fire && ctl_q && ctl_ok && !SERVICE_MODE && ZS_OPTION) |=> FILTER_CHANGE_START)
    else $error("valid filter command not executed");
  a_ctl_ignore: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (fire && ctl_q && !ctl_ok) |=> !FILTER_CHANGE_START)
    else $error("malformed control command executed");

  // ----------------------------------------
  // reply characters
  // ----------------------------------------
  // status layouts
  assign op_st = {3'h0, FILTER_CHANGING, HEATER_OFF, PUMP_OFF, LOCAL_MAINT, SERVICE_MODE};
  assign err_st = {1'b0, ERR_FLOW, ERR_MAINBOARD, ERR_DET_BOARD, 1'b0, ERR_BETA_DET, ERR_FILTER_CHANGE,
                   ERR_FILTER_COUNT};
  // record address counts up from own address
  assign ra = {1'b0, INSTR_ADDR} + {4'h0, idx_q};
  assign mv = MEAS_VALID[idx_q] ? MEAS_MANT[16*idx_q +: 16] : 16'h0;
  assign ev = MEAS_VALID[idx_q] ? MEAS_EXP[8*idx_q +: 8] : 8'h0;
  assign hdr = {`ASC_STX, `ASC_KW_REP0, `ASC_KW_REP1, 4'h3, 4'(MEAS_N / 10), 4'h3, 4'(MEAS_N % 10)};
  // one record per measurement in input order
  assign rec = {`ASC_SP, 4'h3, 4'(ra / 8'd100), 4'h3, 4'((ra / 8'd10) % 8'd10), 4'h3, 4'(ra % 8'd10),
                `ASC_SP, (MEAS_VALID[idx_q] && MEAS_MANT_NEG[idx_q]) ? `ASC_MINUS : `ASC_PLUS,
                4'h3, mv[15:12], 4'h3, mv[11:8], 4'h3, mv[7:4], 4'h3, mv[3:0],
                (MEAS_VALID[idx_q] && MEAS_EXP_NEG[idx_q]) ? `ASC_MINUS : `ASC_PLUS,
                4'h3, ev[7:4], 4'h3, ev[3:0], `ASC_SP, hexc(op_st[7:4]), hexc(op_st[3:0]), `ASC_SP,
                hexc(err_st[7:4]), hexc(err_st[3:0]), `ASC_SP, {10{`ASC_CH_0}}};
  assign trl = {rcr_q ? `ASC_CR : `ASC_ETX, hexc(rck_q[7:4]), hexc(rck_q[3:0])};
  assign hdr_sh = hdr << {pos_q, 3'b000};
  assign rec_sh = rec << {pos_q, 3'b000};
  assign trl_sh = trl << {pos_q, 3'b000};
  always_comb
  begin
    case (rph_q)
      ASC_R_HDR: cur_ch = hdr_sh[39:32];
      ASC_R_MEAS: cur_ch = rec_sh[239:232];
      ASC_R_TRL: cur_ch = trl_sh[23:16];
      default: cur_ch = `ASC_SP;
    endcase
  end

  // ----------------------------------------
  // reply sequencer
  // ----------------------------------------
  // measurements are sampled as each character goes out, not frozen at the query
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      rph_q <= ASC_R_OFF;
      REPLY_ACTIVE <= 1'b0;
      idx_q <= '0;
      pos_q <= '0;
      rck_q <= '0;
      rcr_q <= 1'b0;
      tx_data_q <= '0;
      tx_valid_q <= 1'b0;
    end
    else
    begin
      tx_valid_q <= 1'b0;
      case (rph_q)
        ASC_R_OFF:
          // only a clean query starts a reply; one arriving mid-reply is dropped
          if (fire && !ctl_q && qry_ok)
          begin
            rph_q <= ASC_R_HDR;
            REPLY_ACTIVE <= 1'b1;
            idx_q <= '0;
            pos_q <= '0;
            rck_q <= '0;
            rcr_q <= fire_cr;
          end
        ASC_R_HDR, ASC_R_MEAS, ASC_R_TRL:
          if (tx_ready && !tx_valid_q)
          begin
            tx_data_q <= cur_ch;
            tx_valid_q <= 1'b1;
            // reply checksum covers STX through ETX
            if (rph_q != ASC_R_TRL || pos_q == '0)
              rck_q <= rck_q ^ cur_ch;
            pos_q <= pos_q + 1'b1;
            if (rph_q == ASC_R_HDR && pos_q == `ASC_HDR_LAST)
            begin
              rph_q <= ASC_R_MEAS;
              pos_q <= '0;
            end
            if (rph_q == ASC_R_MEAS && pos_q == `ASC_REC_LAST)
            begin
              pos_q <= '0;
              idx_q <= idx_q + 1'b1;
              if (idx_q == 4'(MEAS_N - 1))
                rph_q <= ASC_R_TRL;
            end
            if (rph_q == ASC_R_TRL && (pos_q == `ASC_TRL_LAST || rcr_q))
              rph_q <= ASC_R_DONE;
          end
        ASC_R_DONE:
          // wait for the last character to leave the line
          if (tx_ready && !tx_valid_q)
          begin
            rph_q <= ASC_R_OFF;
            REPLY_ACTIVE <= 1'b0;
          end
        default:
          rph_q <= ASC_R_OFF;
      endcase
    end
  end

  a_reply_go: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (fire && !ctl_q && qry_ok && rph_q == ASC_R_OFF) |=> REPLY_ACTIVE ##[1:2] (tx_valid_q && tx_data_q == `ASC_STX))
    else $error("valid query not answered with start char");
  a_ck_drop: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (ck_bad && !REPLY_ACTIVE) |=> !REPLY_ACTIVE)
    else $error("reply to frame with bad checksum");
  a_special_function_field_zero: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (rph_q == ASC_R_MEAS && pos_q >= `ASC_R_SPECIAL_FUNCTION_FIELD) |-> cur_ch == `ASC_CH_0)
    else $error("special-function field not zero");
  a_bad_meas: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (rph_q == ASC_R_MEAS && pos_q >= `ASC_R_MDIG && pos_q <= `ASC_R_MEND && !MEAS_VALID[idx_q])
    |-> cur_ch == `ASC_CH_0)
    else $error("invalid measurement not zero");
  a_term_same: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (rph_q == ASC_R_TRL && pos_q == '0) |-> cur_ch == (rcr_q ? `ASC_CR : `ASC_ETX))
    else $error("reply terminator differs from query");
endmodule // asc_responder
`default_nettype wire

// ===== asc_uart.sv
// asynchronous serial transceiver with selectable rate and character format
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module asc_uart
#(
  parameter int CLK_HZ = `ASC_CLK_HZ,
  parameter int CW = 18
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rxd,
  input wire logic [2:0] baud_sel,
  input wire logic eight,
  input wire logic two_stop,
  input wire asc_pkg::asc_par_e parity,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic txd,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  import asc_pkg::*;
  logic [CW-1:0] div;
  logic par_en;
  logic [3:0] nb;
  logic rx_busy_q;
  logic [CW-1:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [10:0] rx_sh_q;
  logic [7:0] rx_dat;
  logic rx_pbit;
  logic rx_perr;
  logic tx_busy_q;
  logic [CW-1:0] tx_cnt_q;
  logic [3:0] tx_left_q;
  logic [10:0] tx_sh_q;
  logic [10:0] pl;
  logic [7:0] tx_msk;

  // ----------------------------------------
  // rate and format
  // ----------------------------------------
  always_comb
  begin
    case (baud_sel)
      3'h0: div = CW'(CLK_HZ / `ASC_BAUD_0);
      3'h1: div = CW'(CLK_HZ / `ASC_BAUD_1);
      3'h2: div = CW'(CLK_HZ / `ASC_BAUD_2);
      3'h3: div = CW'(CLK_HZ / `ASC_BAUD_3);
      3'h4: div = CW'(CLK_HZ / `ASC_BAUD_4);
      3'h5: div = CW'(CLK_HZ / `ASC_BAUD_5);
      3'h6: div = CW'(CLK_HZ / `ASC_BAUD_6);
      default: div = CW'(CLK_HZ / `ASC_BAUD_7);
    endcase
  end
  assign par_en = (parity != ASC_PAR_NONE);
  // data bits, parity bit and first stop bit after the start bit
  assign nb = `ASC_NB_BASE + {3'h0, eight} + {3'h0, par_en};

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  assign rx_dat = eight ? rx_sh_q[7:0] : {1'b0, rx_sh_q[6:0]};
  assign rx_pbit = eight ? rx_sh_q[8] : rx_sh_q[7];
  assign rx_perr = par_en && ((^rx_dat ^ rx_pbit) != (parity == ASC_PAR_ODD));
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_idx_q <= '0;
      rx_sh_q <= '0;
      rx_valid <= 1'b0;
      rx_data <= '0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!rx_busy_q)
      begin
        if (!rxd)
        begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= div >> 1;
          rx_idx_q <= '0;
        end
      end
      else if (rx_cnt_q != '0)
        rx_cnt_q <= rx_cnt_q - 1'b1;
      else
      begin
        rx_cnt_q <= div - 1'b1;
        rx_idx_q <= rx_idx_q + 1'b1;
        // a start bit that is high again at mid-bit was a glitch
        if (rx_idx_q == '0)
          rx_busy_q <= !rxd;
        else if (rx_idx_q == nb)
        begin
          rx_busy_q <= 1'b0;
          // bad stop or parity: the character is dropped
          rx_valid <= rxd && !rx_perr;
          rx_data <= rx_dat;
        end
        else
          rx_sh_q[rx_idx_q - 1'b1] <= rxd;
      end
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  assign tx_ready = !tx_busy_q;
  assign tx_msk = eight ? tx_data : {1'b0, tx_data[6:0]};
  always_comb
  begin
    pl = '1;
    pl[6:0] = tx_data[6:0];
    if (eight)
      pl[7] = tx_data[7];
    if (par_en && eight)
      pl[8] = ^tx_msk ^ (parity == ASC_PAR_ODD);
    if (par_en && !eight)
      pl[7] = ^tx_msk ^ (parity == ASC_PAR_ODD);
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_left_q <= '0;
      tx_sh_q <= '1;
      txd <= 1'b1;
    end
    else if (!tx_busy_q)
    begin
      if (tx_valid)
      begin
        tx_busy_q <= 1'b1;
        txd <= 1'b0;
        tx_sh_q <= pl;
        tx_left_q <= nb + {3'h0, two_stop};
        tx_cnt_q <= div - 1'b1;
      end
    end
    else if (tx_cnt_q != '0)
      tx_cnt_q <= tx_cnt_q - 1'b1;
    else if (tx_left_q == '0)
      tx_busy_q <= 1'b0;
    else
    begin
      txd <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[10:1]};
      tx_left_q <= tx_left_q - 1'b1;
      tx_cnt_q <= div - 1'b1;
    end
  end
endmodule // asc_uart
`default_nettype wire

// ===== tb_ascii_framed_query_responder.sv
// self-checking bench for the ascii framed query responder
`timescale 1ns/1ps
`default_nettype none
module tb_ascii_framed_query_responder;
  import asc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cfg_load = 1'b0, zs = 1'b1;
  logic eb = 1'b1, ts = 1'b0;
  logic [2:0] br = 3'h3;
  asc_par_e pr = ASC_PAR_NONE;
  logic rxd, txd, fcs, ract;
  logic [6:0] cfg_addr = 7'h05, ia;
  logic [7:0] op = '0, er = '0;
  logic [8:0] mv = '0, mn = '0, en = '0;
  logic [143:0] mm = '0;
  logic [71:0] me = '0;
  int err_total, checks_done, pc, rh, tn, ea = 14;
  byte eq[$];
  always #2.5 clk = ~clk;
  always @(posedge clk) if (fcs === 1'b1) pc++;
  always @(posedge clk) if (ract === 1'b1) rh++;
  asc_host #(.DIV(5)) i_host (.clk(clk), .txd(txd), .rxd(rxd));
  // short bit time: 48 kHz core clock gives five cycles a bit at 9600
  asc_responder #(.CLK_HZ(48000)) i_dut (.CORE_CLK(clk), .RESET_N(rst_n), .RXD(rxd), .TXD(txd),
    .CFG_LOAD(cfg_load), .CFG_ADDR(cfg_addr), .CFG_BAUD(br), .CFG_EIGHT_BITS(eb), .CFG_TWO_STOP(ts),
    .CFG_PARITY(pr), .SERVICE_MODE(op[0]), .LOCAL_MAINT(op[1]), .PUMP_OFF(op[2]),
    .HEATER_OFF(op[3]), .FILTER_CHANGING(op[4]), .ZS_OPTION(zs), .ERR_FILTER_COUNT(er[0]),
    .ERR_FILTER_CHANGE(er[1]), .ERR_BETA_DET(er[2]), .ERR_DET_BOARD(er[4]), .ERR_MAINBOARD(er[5]),
    .ERR_FLOW(er[6]), .MEAS_VALID(mv), .MEAS_MANT_NEG(mn), .MEAS_MANT(mm), .MEAS_EXP_NEG(en),
    .MEAS_EXP(me), .FILTER_CHANGE_START(fcs), .REPLY_ACTIVE(ract), .INSTR_ADDR(ia));
  // ---
  // helpers
  // ---
  function automatic byte hx(logic [3:0] n);
    return byte'(n < 10 ? 48 + n : 55 + n);
  endfunction
  // host frames are ten bits long: in seven-bit mode the parity rides in data bit seven
  function automatic byte pa(byte c);
    return eb ? c : byte'({(^c[6:0]) ^ (pr == ASC_PAR_ODD), c[6:0]});
  endfunction
  function automatic void ps(string s);
    foreach (s[k]) eq.push_back(s[k]);
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic rnd();
    @(posedge clk);
    op <= 8'($urandom);
    er <= 8'($urandom);
    mv <= 9'($urandom);
    mn <= 9'($urandom);
    en <= 9'($urandom);
    for (int i = 0; i < 36; i++) mm[4*i+:4] <= 4'($urandom % 10);
    for (int i = 0; i < 18; i++) me[4*i+:4] <= 4'($urandom % 10);
  endtask
  // command frame sender; ck 1 adds a good checksum, 2 a wrong one
  task automatic tx(string s, int ck);
    byte x;
    x = 0;
    @(posedge clk);
    foreach (s[k])
    begin
      x ^= s[k];
      i_host.send(pa(s[k]));
    end
    if (ck > 0)
    begin
      i_host.send(pa(hx(x[7:4])));
      i_host.send(pa(hx(x[3:0] ^ 4'(ck - 1))));
    end
  endtask
  function automatic void mdl(bit etx);
    byte x;
    logic [7:0] o, e;
    o = {3'h0, op[4:0]};
    e = er & 8'h77;
    ps("\002MD09");
    for (int i = 0; i < 9; i++)
    begin
      ps($sformatf(" %03d ", ea + i));
      if (mv[i]) ps($sformatf("%c%04h%c%02h", mn[i] ? "-" : "+", mm[16*i+:16], en[i] ? "-" : "+", me[8*i+:8]));
      else ps("+0000+00");
      ps($sformatf(" %c%c %c%c 0000000000", hx(o[7:4]), hx(o[3:0]), hx(e[7:4]), hx(e[3:0])));
    end
    if (etx)
    begin
      x = 0;
      eq.push_back(8'h03);
      foreach (eq[k]) x ^= eq[k];
      ps($sformatf("%c%c", hx(x[7:4]), hx(x[3:0])));
    end
    else eq.push_back(8'h0d);
  endfunction
  // rep 0 none, 1 carriage return reply, 2 checksummed reply; p filter pulses
  task automatic t(string s, int ck, int rep, int p);
    int n;
    pc = 0;
    rh = 0;
    tx(s, ck);
    eq = {};
    if (rep > 0) mdl(rep == 2);
    for (n = 0; n < 20000 && (n < 300 || ract === 1'b1); n++) @(posedge clk);
    repeat (10) @(posedge clk);
    chk("filter pulses", p, pc);
    chk("reply active", 0, ract);
    chk("reply seen", rep > 0, rh > 0);
    chk("reply length", eq.size(), i_host.rx_q.size());
    foreach (eq[k]) if (k < i_host.rx_q.size()) chk("reply char", pa(eq[k]), i_host.rx_q[k]);
    i_host.rx_q = {};
    $display("test %0d done", tn++);
  endtask
  // ---
  // sequence
  // ---
  initial
  begin
    repeat (80000) @(posedge clk);
    err_total++;
    $display("wrong value watchdog expected 0 seen 1");
    complete_run();
  end
  initial
  begin
    void'($urandom(32'h71690561));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("address", 14, ia);
    chk("txd idle", 1, txd);
    rnd();
    t("\002DA\015", 0, 1, 0);
    rnd();
    t("\002DA 014\003", 1, 2, 0);
    t("\002DA\003", 2, 0, 0);
    t("\002DA \015", 0, 0, 0);
    t("\002DA015\015", 0, 0, 0);
    t("xy\002ST\002DA014 \015", 0, 1, 0);
    op <= 8'h00;
    t("\002ST014 N\015", 0, 0, 1);
    t("\002STN\003", 1, 0, 1);
    t("\002ST015N\015", 0, 0, 0);
    t("\002ST014 X\015", 0, 0, 0);
    op <= 8'h01;
    t("\002STN\015", 0, 0, 0);
    op <= 8'h00;
    zs <= 1'b0;
    t("\002STN\015", 0, 0, 0);
    zs <= 1'b1;
    // seven data bits, even parity and two stop bits arrive with the new address
    eb <= 1'b0;
    pr <= ASC_PAR_EVEN;
    ts <= 1'b1;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    ea = 5;
    repeat (3) @(posedge clk);
    chk("address", 5, ia);
    t("\002DA  5\015", 0, 1, 0);
    complete_run();
  end
endmodule // tb_ascii_framed_query_responder
`default_nettype wire
